// >>> verilog/pwg_pkg.sv
// package of constants for the pulse-width waveform generator
// Overview of operation
// - off count: low byte then high byte
// - on count: low byte then high byte
// - counts latch on on-time high write
// - counts advance on 2 us ticks
// - single-period mode clears enable after period
// - optional AND with gating input pin
package pwg_pkg;
   // register indices; each register is one word, so the byte address is index * 4
   localparam logic [7:0]  IDX_OFF_LOW   = 8'h2f;
   localparam logic [7:0]  IDX_OFF_HIGH  = 8'h30;
   localparam logic [7:0]  IDX_ON_LOW    = 8'h31;
   localparam logic [7:0]  IDX_ON_HIGH   = 8'h32;
   localparam logic [7:0]  IDX_CFG       = 8'h33;
   localparam logic [9:0]  ADDR_OFF_LOW  = {IDX_OFF_LOW, 2'b00};
   localparam logic [9:0]  ADDR_OFF_HIGH = {IDX_OFF_HIGH, 2'b00};
   localparam logic [9:0]  ADDR_ON_LOW   = {IDX_ON_LOW, 2'b00};
   localparam logic [9:0]  ADDR_ON_HIGH  = {IDX_ON_HIGH, 2'b00};
   localparam logic [9:0]  ADDR_CFG      = {IDX_CFG, 2'b00};
   // config field positions
   localparam int          CFG_EN_BIT    = 0;
   localparam int          CFG_MODE_BIT  = 1;
   localparam int          CFG_AND_BIT   = 2;
   localparam logic [7:0]  CFG_MASK      = 8'h07;
   localparam logic [7:0]  RESET_BYTE    = 8'h00;
   // tick timing
   localparam int          CLK_HZ        = 125000000;
   localparam int          TICK_NS       = 2000;
   localparam int          CLK_NS        = 8;
   localparam int          TICK_CYCLES   = TICK_NS / CLK_NS;
   localparam logic [7:0]  TICK_LAST     = 8'(TICK_CYCLES - 1);
   typedef enum logic [1:0] {PWG_IDLE, PWG_ON, PWG_OFF} pwg_state_t;
endpackage : pwg_pkg

// >>> verilog/pwg_tick.sv
// tick divider producing one pulse per count period
`timescale 1ns/1ns
module pwg_tick (
   input  wire logic clk_sys_i,
   input  wire logic reset_i,
   input  wire logic run_i,
   output logic      tick_o
);
   logic [7:0] cnt;
   logic [7:0] next_cnt;

   // restart from zero whenever idle so the first count is full length
   always_comb begin
      next_cnt = cnt + 8'h01;
      if (!run_i || cnt == pwg_pkg::TICK_LAST) begin
         next_cnt = 8'h00;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         cnt <= 8'h00;
      end else begin
         cnt <= next_cnt;
      end
   end

   assign tick_o = run_i && (cnt == pwg_pkg::TICK_LAST);
endmodule : pwg_tick

// >>> verilog/pwg_top.sv
// top of pulse-width waveform generator with apb register slave
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
module pwg_top (
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        gating_input_pin_i,
   output logic             pulse_o
);
   logic [7:0]            off_count_low;
   logic [7:0]            off_count_high;
   logic [7:0]            on_count_low;
   logic [7:0]            on_count_high;
   logic [7:0]            cfg;
   logic [15:0]           on_latch;
   logic [15:0]           off_latch;
   logic [15:0]           cnt;
   pwg_pkg::pwg_state_t   state;
   logic [31:0]           rdata;
   logic                  pulse;
   logic                  gate_s1;
   logic                  gate_s2;
   logic [7:0]            next_off_count_low;
   logic [7:0]            next_off_count_high;
   logic [7:0]            next_on_count_low;
   logic [7:0]            next_on_count_high;
   logic [7:0]            next_cfg;
   logic [15:0]           next_on_latch;
   logic [15:0]           next_off_latch;
   logic [15:0]           next_cnt;
   pwg_pkg::pwg_state_t   next_state;
   logic [31:0]           next_rdata;
   logic                  next_pulse;
   logic                  wr;
   logic                  rd;
   logic                  hit;
   logic                  tick;
   logic                  one_done;

   // zero-wait slave: every access completes in its first access cycle
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !hit;
   assign wr        = psel_i && penable_i && pwrite_i && pstrb_i[0];
   assign rd        = psel_i && penable_i && !pwrite_i;
   assign prdata_o  = rdata;

   // address decode, bits [1:0] ignored since words are aligned
   // upper address bits must be zero; anything else is refused with an error
   always_comb begin
      hit = 1'b1;
      case ({paddr_i[11:2], 2'b00})
         {2'b00, pwg_pkg::ADDR_OFF_LOW}:  next_rdata = {24'h000000, off_count_low};
         {2'b00, pwg_pkg::ADDR_OFF_HIGH}: next_rdata = {24'h000000, off_count_high};
         {2'b00, pwg_pkg::ADDR_ON_LOW}:   next_rdata = {24'h000000, on_count_low};
         {2'b00, pwg_pkg::ADDR_ON_HIGH}:  next_rdata = {24'h000000, on_count_high};
         {2'b00, pwg_pkg::ADDR_CFG}:      next_rdata = {24'h000000, cfg};
         default: begin
            hit        = 1'b0;
            next_rdata = 32'h00000000;
         end
      endcase
      if (!(psel_i && !penable_i)) begin
         next_rdata = rdata; // read data captured in setup, held through access
      end
   end

   // register writes; byte pairs form the 16-bit counts
   always_comb begin
      next_off_count_low  = off_count_low;
      next_off_count_high = off_count_high;
      next_on_count_low   = on_count_low;
      next_on_count_high  = on_count_high;
      next_cfg            = cfg;
      next_on_latch       = on_latch;
      next_off_latch      = off_latch;
      // reserved config bits are masked off here, so they always read as zero
      if (wr && hit) begin
         case (paddr_i[9:2])
            pwg_pkg::IDX_OFF_LOW:  next_off_count_low  = pwdata_i[7:0];
            pwg_pkg::IDX_OFF_HIGH: next_off_count_high = pwdata_i[7:0];
            pwg_pkg::IDX_ON_LOW:   next_on_count_low   = pwdata_i[7:0];
            pwg_pkg::IDX_ON_HIGH: begin
               next_on_count_high = pwdata_i[7:0];
               // only this write moves the counts into the generator
               next_on_latch  = {pwdata_i[7:0], on_count_low};
               next_off_latch = {off_count_high, off_count_low};
            end
            pwg_pkg::IDX_CFG:      next_cfg = pwdata_i[7:0] & pwg_pkg::CFG_MASK;
            default:               next_cfg = cfg;
         endcase
      end
      // self-clear wins over a write in the same cycle so the period still ends
      if (one_done) begin
         next_cfg[pwg_pkg::CFG_EN_BIT] = 1'b0;
      end
   end

   // the divider runs only while a period is in progress, so it restarts when the
   // sequencer leaves idle and the first on phase is as long as the later ones
   pwg_tick pwg_tick_inst (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .run_i     (state != pwg_pkg::PWG_IDLE),
      .tick_o    (tick)
   );

   // period sequencer: on phase, then off phase
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      one_done   = 1'b0;
      // a zero count is served as one tick; the output stays low for a zero on count
      case (state)
         pwg_pkg::PWG_IDLE: begin
            next_cnt = 16'h0000;
            if (cfg[pwg_pkg::CFG_EN_BIT]) begin
               next_state = pwg_pkg::PWG_ON;
            end
         end
         pwg_pkg::PWG_ON: begin
            if (tick) begin
               next_cnt = cnt + 16'h0001;
               if (cnt + 16'h0001 >= on_latch || on_latch == 16'h0000) begin
                  next_cnt   = 16'h0000;
                  next_state = pwg_pkg::PWG_OFF;
               end
            end
         end
         pwg_pkg::PWG_OFF: begin
            if (tick) begin
               next_cnt = cnt + 16'h0001;
               if (cnt + 16'h0001 >= off_latch || off_latch == 16'h0000) begin
                  next_cnt   = 16'h0000;
                  next_state = pwg_pkg::PWG_ON;
                  if (cfg[pwg_pkg::CFG_MODE_BIT]) begin
                     one_done   = 1'b1;
                     next_state = pwg_pkg::PWG_IDLE;
                  end
               end
            end
         end
         default: next_state = pwg_pkg::PWG_IDLE;
      endcase
      if (!cfg[pwg_pkg::CFG_EN_BIT]) begin
         next_state = pwg_pkg::PWG_IDLE;
         next_cnt   = 16'h0000;
      end
   end

   // output, optionally gated by the synchronised pin
   // the pin reaches the output three clocks late; pin pulses shorter than one clock may be lost
   always_comb begin
      next_pulse = (state == pwg_pkg::PWG_ON) && (on_latch != 16'h0000);
      if (cfg[pwg_pkg::CFG_AND_BIT]) begin
         next_pulse = next_pulse && gate_s2;
      end
   end

   // register bank flops
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         off_count_low  <= pwg_pkg::RESET_BYTE;
         off_count_high <= pwg_pkg::RESET_BYTE;
         on_count_low   <= pwg_pkg::RESET_BYTE;
         on_count_high  <= pwg_pkg::RESET_BYTE;
         cfg            <= pwg_pkg::RESET_BYTE;
         on_latch       <= 16'h0000;
         off_latch      <= 16'h0000;
      end else begin
         off_count_low  <= next_off_count_low;
         off_count_high <= next_off_count_high;
         on_count_low   <= next_on_count_low;
         on_count_high  <= next_on_count_high;
         cfg            <= next_cfg;
         on_latch       <= next_on_latch;
         off_latch      <= next_off_latch;
      end
   end

   // read data flop; it only moves in a setup cycle
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         rdata <= 32'h00000000;
      end else begin
         rdata <= next_rdata;
      end
   end

   // sequencer flops
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         cnt   <= 16'h0000;
         state <= pwg_pkg::PWG_IDLE;
      end else begin
         cnt   <= next_cnt;
         state <= next_state;
      end
   end

   // output flop and pin synchroniser; logic reads only the second stage
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         pulse   <= 1'b0;
         gate_s1 <= 1'b0;
         gate_s2 <= 1'b0;
      end else begin
         pulse   <= next_pulse;
         gate_s1 <= gating_input_pin_i;
         gate_s2 <= gate_s1;
      end
   end

   assign pulse_o = pulse;
endmodule : pwg_top

// >>> test/pwg_sva.sv
// port checker for the pulse-width waveform generator
`timescale 1ns/1ns
module pwg_sva (
   input wire logic        clk_sys_i,
   input wire logic        reset_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0]  pstrb_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        gating_input_pin_i,
   input wire logic        pulse_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   logic acc;
   logic hit;
   logic and_en;
   // own decode, kept apart from the design's
   assign acc = psel_i & penable_i;
   assign hit = paddr_i[11:2] >= 10'h2f && paddr_i[11:2] <= 10'h33;
   // mirror of the gating bit, needed to judge the output
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) and_en <= 1'h0;
      else if (acc & pwrite_i & pstrb_i[0] & paddr_i[11:2] == 10'h33) and_en <= pwdata_i[2];
   end
   property p_ready; 1'h1 |-> pready_o; endproperty
   property p_err; acc |-> pslverr_o == !hit; endproperty
   property p_noerr; !acc |-> !pslverr_o; endproperty
   property p_upper; acc && !pwrite_i |-> prdata_o[31:8] == 24'h0; endproperty
   property p_rsv; acc && !pwrite_i && paddr_i[11:2] == 10'h33 |-> prdata_o[7:3] == 5'h0;
   endproperty
   property p_unmap; acc && !pwrite_i && !hit |-> prdata_o == 32'h0; endproperty
   property p_hold; acc |=> $stable(prdata_o); endproperty
   // pin passes two sync stages and the output flop
   property p_gate; and_en && pulse_o |->
      $past(gating_input_pin_i, 2) || $past(gating_input_pin_i, 3); endproperty
   property p_rst; disable iff (1'h0) reset_i |=> !pulse_o && prdata_o == 32'h0;
   endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   a_err: assert property (p_err) else $error("pslverr wrong in access");
   a_noerr: assert property (p_noerr) else $error("pslverr outside access");
   a_upper: assert property (p_upper) else $error("read data upper bits set");
   a_rsv: assert property (p_rsv) else $error("reserved config bits set");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_hold: assert property (p_hold) else $error("read data moved");
   a_gate: assert property (p_gate) else $error("output high with pin low");
   a_rst: assert property (p_rst) else $error("output not idle in reset");
   c_gate: cover property (and_en && pulse_o);
   c_err: cover property (pslverr_o);
   c_pulse: cover property ($rose(pulse_o));
endmodule : pwg_sva
bind pwg_top pwg_sva pwg_sva_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .gating_input_pin_i(gating_input_pin_i), .pulse_o(pulse_o));

// >>> test/pwg_load.sv
// load model on the pulse output: measures run lengths and rises
`timescale 1ns/1ns
module pwg_load (
   input  wire logic        clk_sys_i,
   input  wire logic        pulse_i,
   output logic      [31:0] hi_len_o = '0,
   output logic      [31:0] lo_len_o = '0,
   output logic      [31:0] rises_o = '0
);
   logic [31:0] run = '0;
   logic        last = 1'h0;
   // a run length is latched when the level changes
   always @(posedge clk_sys_i) begin
      if (pulse_i === ~last) begin
         if (last) hi_len_o <= run;
         else lo_len_o <= run;
         rises_o <= rises_o + {31'h0, pulse_i};
         run <= 32'h1;
      end
      else run <= run + 32'h1;
      last <= pulse_i;
   end
endmodule : pwg_load

// >>> test/pwm_waveform_generator_bench.sv
// self-checking bench for the pulse-width waveform generator
`timescale 1ns/1ns
module pwm_waveform_generator_bench;
   typedef struct { logic [11:0] a; logic [7:0] w; logic [7:0] e; } pwg_row_t;
   localparam int T = pwg_pkg::TICK_CYCLES;
   logic clk_sys_i = 1'h0, reset_i = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic pin = 1'h0, pready, pslverr, pulse, err;
   logic [11:0] paddr = '0;
   logic [3:0] strb = 4'hf;
   logic [31:0] pwdata = '0, prdata, hi_len, lo_len, rises, r;
   int n_errors = 0, comparisons = 0, k, base;
   // plain rows, a config row whose reserved bits read back as zero, then an unmapped place
   pwg_row_t rows [6] = '{'{12'h0bc, 8'ha5, 8'ha5}, '{12'h0c0, 8'h3c, 8'h3c},
      '{12'h0c4, 8'hc3, 8'hc3}, '{12'h0c8, 8'h7e, 8'h7e}, '{12'h0cc, 8'hf8, 8'h00},
      '{12'h000, 8'hff, 8'h00}};
   pwg_top pwg_top_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .pstrb_i(strb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .gating_input_pin_i(pin), .pulse_o(pulse));
   pwg_load pwg_load_inst (.clk_sys_i(clk_sys_i), .pulse_i(pulse), .hi_len_o(hi_len),
      .lo_len_o(lo_len), .rises_o(rises));
   initial forever #4 clk_sys_i = ~clk_sys_i;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one apb transfer; answer taken at the edge where pready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys_i);
      penable <= 1'h1;
      do @(posedge clk_sys_i); while (pready !== 1'h1);
      r = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic wait_rises(input logic [31:0] n);
      for (k = 0; k < 20000 && rises < n; k++) @(posedge clk_sys_i);
   endtask : wait_rises
   task automatic results;
      $display("n_errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results
   initial begin
      repeat (8) @(posedge clk_sys_i);
      reset_i <= 1'h0;
      for (int i = 0; i < 5; i++) begin
         apb(1'h0, 12'h0bc + 12'(4 * i), 8'h0);
         check(r, 32'h0);
      end
      foreach (rows[i]) begin
         apb(1'h1, rows[i].a, rows[i].w);
         check({31'h0, err}, {31'h0, rows[i].a == 12'h000});
         apb(1'h0, rows[i].a, 8'h0);
         check(r, {24'h0, rows[i].e});
      end
      // on 2 ticks, off 1; a lone low byte must wait for the high byte
      apb(1'h1, 12'h0bc, 8'h01);
      apb(1'h1, 12'h0c0, 8'h00);
      apb(1'h1, 12'h0c4, 8'h02);
      apb(1'h1, 12'h0c8, 8'h00);
      apb(1'h1, 12'h0c4, 8'h05);
      apb(1'h1, 12'h0cc, 8'h01);
      wait_rises(rises + 3);
      check(hi_len, 2 * T);
      check(lo_len, T);
      apb(1'h1, 12'h0c8, 8'h00);
      wait_rises(rises + 2);
      for (k = 0; k < 5000 && pulse; k++) @(posedge clk_sys_i);
      // the load latches the run length at this edge, so look one edge later
      @(posedge clk_sys_i);
      check(hi_len, 5 * T);
      apb(1'h1, 12'h0cc, 8'h00);
      repeat (2 * T) @(posedge clk_sys_i);
      check({31'h0, pulse}, 32'h0);
      // single period then the enable clears itself
      base = rises;
      apb(1'h1, 12'h0cc, 8'h03);
      repeat (10 * T) @(posedge clk_sys_i);
      apb(1'h0, 12'h0cc, 8'h00);
      check(r, 32'h2);
      check(rises, base + 1);
      // gated by a low pin, then released
      base = rises;
      apb(1'h1, 12'h0cc, 8'h05);
      repeat (8 * T) @(posedge clk_sys_i);
      check(rises, base);
      pin <= 1'h1;
      wait_rises(base + 1);
      check(rises, base + 1);
      // reset in mid-run drops the output and clears the bank
      reset_i <= 1'h1;
      repeat (2) @(posedge clk_sys_i);
      check({31'h0, pulse}, 32'h0);
      reset_i <= 1'h0;
      apb(1'h0, 12'h0cc, 8'h00);
      check(r, 32'h0);
      // a write without its low byte strobe leaves the register alone
      strb <= 4'h0;
      apb(1'h1, 12'h0bc, 8'h77);
      strb <= 4'hf;
      apb(1'h0, 12'h0bc, 8'h00);
      check(r, 32'h0);
      results();
   end
   initial begin
      repeat (60000) @(posedge clk_sys_i);
      n_errors++;
      results();
   end
endmodule : pwm_waveform_generator_bench
